// *** vic_consts.svh ***
// Purpose: constants of the vectored interrupt controller
// Assumes: included by the package and by every design file
// Notes:   byte offsets are word aligned on the register bus
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// sizes
`define VIC_NSRC      144
`define VIC_NWORD     5
`define VIC_PADW      160
`define VIC_CTXW      104
`define VIC_SLOTW     128
`define VIC_VECW      8

// register byte offsets
`define VIC_A_CTRL    8'h00
`define VIC_A_STAT    8'h04
`define VIC_A_FLAG    8'h10
`define VIC_A_ENAB    8'h30
`define VIC_A_PRIO    8'h50
`define VIC_A_SHAD    8'h70

// control field positions
`define VIC_F_GLOBAL_HIGH_ENABLE    0
`define VIC_F_GLOBAL_LOW_ENABLE    1
`define VIC_F_PRIORITY_LEVELS_ENABLE    2
`define VIC_F_VTEN    3
`define VIC_F_SHSEL   4

// reset values
`define VIC_CTRL_RST  5'h00
`define VIC_ENAB_RST  160'h0
`define VIC_PRIO_RST  {160{1'b1}}

// branch targets without the vector table
`define VIC_FIXED_ADDR 16'h0008
`define VIC_LOW_ADDR   16'h0018

`endif

// *** vic_pkg.sv ***
// Purpose: types of the vectored interrupt controller
// Assumes: vic_consts.svh holds the numbers
// Notes:   state codes are visible in the status register, ST_NEST as ST_HIGH
`include "vic_consts.svh"
package vic_pkg;

    typedef enum logic [1:0] {
        ST_MAIN = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_NEST = 2'b11
    } vic_state_t;

    typedef enum logic {
        SLOT_MAIN = 1'b0,
        SLOT_LOW  = 1'b1
    } vic_slot_t;

    typedef struct packed {
        logic [`VIC_PADW-1:0] flag;
        logic [`VIC_PADW-1:0] enab;
        logic [`VIC_PADW-1:0] prio;
        logic [4:0]           ctrl;
        vic_state_t           st;
        logic                 req;
        logic                 req_high;
        logic [`VIC_VECW-1:0] req_vec;
        logic                 table_en;
        logic [15:0]          addr;
        logic                 wload;
        logic [`VIC_VECW-1:0] wdata;
        logic                 push;
        logic                 pop;
        logic                 rst_ctx;
        logic [`VIC_CTXW-1:0] ctx;
        logic [1:0]           exec;
        logic                 ph_wr;
        logic                 ph_rd;
        logic [7:0]           ph_addr;
        logic [31:0]          hrdata;
        logic                 hready;
    } vic_top_t;

    typedef struct packed {
        logic [`VIC_SLOTW-1:0] main_ctx;
        logic [`VIC_SLOTW-1:0] low_ctx;
    } vic_store_t;

endpackage

// *** vic_ctx_if.sv ***
// Purpose: link between controller and context store
// Assumes: both ends on the same clock
// Notes:   save wins over a software write in the same cycle
`timescale 1ns/1ns
`include "vic_consts.svh"
interface vic_ctx_if;
    import vic_pkg::*;
    logic                  save;
    vic_slot_t             save_slot;
    logic [`VIC_CTXW-1:0]  save_data;
    logic                  wr;
    vic_slot_t             wr_slot;
    logic [1:0]            wr_word;
    logic [31:0]           wr_data;
    vic_slot_t             rd_slot;
    logic [`VIC_CTXW-1:0]  rd_data;
    vic_slot_t             win_slot;
    logic [`VIC_SLOTW-1:0] win_data;

    modport ctl (output save, save_slot, save_data, wr, wr_slot, wr_word,
                 output wr_data, rd_slot, win_slot,
                 input  rd_data, win_data);
    modport store (input  save, save_slot, save_data, wr, wr_slot, wr_word,
                   input  wr_data, rd_slot, win_slot,
                   output rd_data, win_data);
endinterface

// *** vic_prio_enc.sv ***
// Purpose: lowest-index finder over a request vector
// Assumes: purely combinational
// Notes:   index 0 wins over every other
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_prio_enc
#(
    parameter int N = `VIC_PADW
)
(
    // requests
    input  wire logic [N-1:0]           req,
    // result
    output logic                        found,
    output logic [`VIC_VECW-1:0]        idx
);
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = `VIC_VECW'(i);
            end
        end
    end
endmodule

// *** vic_ctx_store.sv ***
// Purpose: two-slot shadow context store
// Assumes: one save or one window write per cycle
// Notes:   bits above the context width read as zero
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_ctx_store
    import vic_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // controller side
    vic_ctx_if.store  cif
);
    localparam logic [`VIC_SLOTW-1:0] MASK = {24'h0, {`VIC_CTXW{1'b1}}};

    vic_store_t q;
    vic_store_t d;

    always_comb begin
        d = q;
        // software edit of a saved context
        if (cif.wr && cif.wr_slot == SLOT_MAIN) begin
            d.main_ctx[cif.wr_word*32 +: 32] = cif.wr_data;
        end
        if (cif.wr && cif.wr_slot == SLOT_LOW) begin
            d.low_ctx[cif.wr_word*32 +: 32] = cif.wr_data;
        end
        // hardware save, two levels deep
        if (cif.save && cif.save_slot == SLOT_MAIN) begin
            d.main_ctx = {24'h0, cif.save_data};
        end
        if (cif.save && cif.save_slot == SLOT_LOW) begin
            d.low_ctx = {24'h0, cif.save_data};
        end
        d.main_ctx = d.main_ctx & MASK;
        d.low_ctx  = d.low_ctx & MASK;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // one window onto both slots
    assign cif.win_data = (cif.win_slot == SLOT_LOW) ? q.low_ctx
                                                     : q.main_ctx;
    assign cif.rd_data  = (cif.rd_slot == SLOT_LOW)
                          ? q.low_ctx[`VIC_CTXW-1:0]
                          : q.main_ctx[`VIC_CTXW-1:0];
endmodule

// *** vic_ctrl.sv ***
// Purpose: vectored interrupt controller with AHB-Lite registers
// Assumes: peripherals and core run on CLK
// Notes:   reads take one wait state, writes none
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_ctrl
    import vic_pkg::*;
#(
    parameter logic [`VIC_NSRC-1:0] SUMMARY_MASK = '0
)
(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  SRST,
    // ahb-lite slave
    input  wire logic                  HSEL,
    input  wire logic [31:0]           HADDR,
    input  wire logic [1:0]            HTRANS,
    input  wire logic                  HWRITE,
    input  wire logic [2:0]            HSIZE,
    input  wire logic [31:0]           HWDATA,
    input  wire logic                  HREADY,
    output logic [31:0]                HRDATA,
    output logic                       HREADYOUT,
    output logic                       HRESP,
    // peripheral sources
    input  wire logic [`VIC_NSRC-1:0]  SRC_EVT,
    input  wire logic [`VIC_NSRC-1:0]  SRC_HWCLR,
    // core request
    output logic                       IRQ_REQ,
    output logic                       IRQ_HIGH,
    output logic [`VIC_VECW-1:0]       IRQ_VEC,
    output logic                       IRQ_TABLE,
    output logic [15:0]                IRQ_ADDR,
    input  wire logic                  CPU_ACK,
    // core return
    input  wire logic                  CPU_RETURN_FROM_INTERRUPT,
    input  wire logic                  CPU_RETURN_FROM_INTERRUPT_CTX,
    // core context
    input  wire logic [`VIC_CTXW-1:0]  CPU_CTX,
    output logic                       WORKING_REGISTER_LOAD,
    output logic [`VIC_VECW-1:0]       WORKING_REGISTER_DATA,
    output logic                       PC_PUSH,
    output logic                       PC_POP,
    output logic                       CTX_RESTORE,
    output logic [`VIC_CTXW-1:0]       CTX_DATA,
    output logic [1:0]                 EXEC_STATE
);
    vic_top_t q;
    vic_top_t d;

    vic_ctx_if cif ();

    logic [`VIC_PADW-1:0] vmask;
    logic [`VIC_PADW-1:0] smask;
    logic [`VIC_PADW-1:0] evt;
    logic [`VIC_PADW-1:0] hwc;
    logic [`VIC_PADW-1:0] pend;
    logic [`VIC_PADW-1:0] hv;
    logic [`VIC_PADW-1:0] lv;
    logic                 hi_found;
    logic                 lo_found;
    logic [`VIC_VECW-1:0] hi_idx;
    logic [`VIC_VECW-1:0] lo_idx;
    logic                 global_high_enable;
    logic                 global_low_enable;
    logic                 priority_levels_enable;
    logic                 vten;
    logic                 take;

    function automatic logic [3:0] widx(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [3:0] n);
        logic [7:0] o;
        o = a - b;
        widx = (a >= b && o[7:2] < {2'b00, n}) ? o[5:2] : 4'hf;
    endfunction

    assign vmask = {16'h0, {`VIC_NSRC{1'b1}}};
    assign smask = {16'h0, SUMMARY_MASK};
    assign evt   = {16'h0, SRC_EVT};
    assign hwc   = {16'h0, SRC_HWCLR};
    assign global_high_enable  = q.ctrl[`VIC_F_GLOBAL_HIGH_ENABLE];
    assign global_low_enable  = q.ctrl[`VIC_F_GLOBAL_LOW_ENABLE];
    assign priority_levels_enable  = q.ctrl[`VIC_F_PRIORITY_LEVELS_ENABLE];
    assign vten  = q.ctrl[`VIC_F_VTEN];
    assign take  = HSEL && HTRANS[1] && HREADY;

    // pending sources split by user level
    assign pend = q.flag & q.enab & vmask;
    assign hv   = priority_levels_enable ? (pend & q.prio) : pend;
    assign lv   = priority_levels_enable ? (pend & ~q.prio) : '0;

    vic_prio_enc #(.N(`VIC_PADW)) u_hi_enc (
        .req   (hv),
        .found (hi_found),
        .idx   (hi_idx)
    );

    vic_prio_enc #(.N(`VIC_PADW)) u_lo_enc (
        .req   (lv),
        .found (lo_found),
        .idx   (lo_idx)
    );

    vic_ctx_store u_store (
        .clk  (CLK),
        .srst (SRST),
        .cif  (cif.store)
    );

    always_comb begin
        logic [`VIC_PADW-1:0] swc;
        logic [31:0]          rd;
        logic [3:0]           fi;
        logic [3:0]           ei;
        logic [3:0]           pi;
        logic [3:0]           si;
        logic                 hi_ok;
        logic                 lo_ok;
        logic                 ack;
        swc   = '0;
        rd    = 32'h0;
        fi    = widx(q.ph_addr, `VIC_A_FLAG, 4'd5);
        ei    = widx(q.ph_addr, `VIC_A_ENAB, 4'd5);
        pi    = widx(q.ph_addr, `VIC_A_PRIO, 4'd5);
        si    = widx(q.ph_addr, `VIC_A_SHAD, 4'd4);
        hi_ok = hi_found && global_high_enable;
        lo_ok = lo_found && global_low_enable && priority_levels_enable;
        ack   = CPU_ACK && q.req;
        d         = q;
        d.wload   = 1'b0;
        d.push    = 1'b0;
        d.pop     = 1'b0;
        d.rst_ctx = 1'b0;
        cif.save      = 1'b0;
        cif.save_slot = SLOT_MAIN;
        cif.save_data = CPU_CTX;
        cif.wr        = 1'b0;
        cif.wr_slot   = q.ctrl[`VIC_F_SHSEL] ? SLOT_LOW : SLOT_MAIN;
        cif.wr_word   = si[1:0];
        cif.wr_data   = HWDATA;
        cif.win_slot  = q.ctrl[`VIC_F_SHSEL] ? SLOT_LOW : SLOT_MAIN;
        cif.rd_slot   = (q.st == ST_NEST) ? SLOT_LOW : SLOT_MAIN;

        // bus write data phase
        if (q.ph_wr && q.ph_addr == `VIC_A_CTRL) begin
            d.ctrl = HWDATA[4:0];
        end
        for (int w = 0; w < `VIC_NWORD; w++) begin
            if (q.ph_wr && fi == 4'(w)) begin
                swc[w*32 +: 32] = HWDATA;
            end
            if (q.ph_wr && ei == 4'(w)) begin
                d.enab[w*32 +: 32] = HWDATA;
            end
            if (q.ph_wr && pi == 4'(w)) begin
                d.prio[w*32 +: 32] = HWDATA;
            end
        end
        if (q.ph_wr && si != 4'hf) begin
            cif.wr = 1'b1;
        end
        d.enab = d.enab & vmask;
        d.prio = d.prio & vmask;

        // sticky flags, set wins over clear; SUMMARY_MASK flags follow their event
        d.flag = ((q.flag & ~swc & ~hwc) | evt) & vmask;
        d.flag = (d.flag & ~smask) | (evt & smask);

        // vectoring accepted by the core
        if (ack) begin
            cif.save      = 1'b1;
            cif.save_slot = (q.st == ST_LOW) ? SLOT_LOW : SLOT_MAIN;
            d.push  = 1'b1;
            d.wload = 1'b1;
            d.wdata = q.req_vec;
            if (q.req_high) begin
                d.st = (q.st == ST_LOW) ? ST_NEST : ST_HIGH;
            end else begin
                d.st = ST_LOW;
            end
        end else if (CPU_RETURN_FROM_INTERRUPT) begin
            d.pop = 1'b1;
            d.ctx = cif.rd_data;
            if (CPU_RETURN_FROM_INTERRUPT_CTX && q.st != ST_MAIN) begin
                d.rst_ctx = 1'b1;
            end
            unique case (q.st)
                ST_MAIN: d.st = ST_MAIN;
                ST_LOW:  d.st = ST_MAIN;
                ST_HIGH: d.st = ST_MAIN;
                ST_NEST: d.st = ST_LOW;
            endcase
        end

        // software dropping the global enables
        if (!global_high_enable) begin
            d.st = ST_MAIN;
        end else if (priority_levels_enable && !global_low_enable && d.st == ST_LOW) begin
            d.st = ST_MAIN;
        end

        // request towards the core
        d.req      = 1'b0;
        d.req_high = 1'b0;
        unique case (q.st)
            ST_MAIN: begin
                if (hi_ok) begin
                    d.req      = 1'b1;
                    d.req_high = 1'b1;
                    d.req_vec  = hi_idx;
                end else if (lo_ok) begin
                    d.req     = 1'b1;
                    d.req_vec = lo_idx;
                end
            end
            ST_LOW: begin
                if (hi_ok) begin
                    d.req      = 1'b1;
                    d.req_high = 1'b1;
                    d.req_vec  = hi_idx;
                end
            end
            ST_HIGH, ST_NEST: d.req = 1'b0;
        endcase
        if (ack || CPU_RETURN_FROM_INTERRUPT || !global_high_enable) begin
            d.req = 1'b0;
        end
        d.table_en = vten;
        if (vten) begin
            d.addr = 16'h0000;
        end else if (priority_levels_enable && !d.req_high) begin
            d.addr = `VIC_LOW_ADDR;
        end else begin
            d.addr = `VIC_FIXED_ADDR;
        end
        d.exec = (d.st == ST_NEST) ? 2'(ST_HIGH) : 2'(d.st);

        // bus read data
        if (q.ph_addr == `VIC_A_CTRL) begin
            rd = {27'h0, q.ctrl};
        end else if (q.ph_addr == `VIC_A_STAT) begin
            rd = {16'h0, q.req_vec, 5'h0, q.req, q.exec};
        end
        for (int w = 0; w < `VIC_NWORD; w++) begin
            if (fi == 4'(w)) begin
                rd = q.flag[w*32 +: 32];
            end
            if (ei == 4'(w)) begin
                rd = q.enab[w*32 +: 32];
            end
            if (pi == 4'(w)) begin
                rd = q.prio[w*32 +: 32];
            end
        end
        if (si != 4'hf) begin
            rd = cif.win_data[si[1:0]*32 +: 32];
        end

        // bus address phase
        d.ph_wr   = take && HWRITE;
        d.ph_rd   = take && !HWRITE;
        d.ph_addr = HADDR[7:0];
        d.hready  = !(take && !HWRITE);
        if (q.ph_rd) begin
            d.hrdata = rd;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            q        <= '0;
            q.ctrl   <= `VIC_CTRL_RST;
            q.enab   <= `VIC_ENAB_RST;
            q.prio   <= `VIC_PRIO_RST & {16'h0, {`VIC_NSRC{1'b1}}};
            q.addr   <= `VIC_FIXED_ADDR;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign HRDATA      = q.hrdata;
    assign HREADYOUT   = q.hready;
    assign HRESP       = 1'b0;
    assign IRQ_REQ     = q.req;
    assign IRQ_HIGH    = q.req_high;
    assign IRQ_VEC     = q.req_vec;
    assign IRQ_TABLE   = q.table_en;
    assign IRQ_ADDR    = q.addr;
    assign WORKING_REGISTER_LOAD   = q.wload;
    assign WORKING_REGISTER_DATA   = q.wdata;
    assign PC_PUSH     = q.push;
    assign PC_POP      = q.pop;
    assign CTX_RESTORE = q.rst_ctx;
    assign CTX_DATA    = q.ctx;
    assign EXEC_STATE  = q.exec;
endmodule

// *** vic_ctrl_chk.sv ***
// Purpose: concurrent checks on the controller ports
// Assumes: one clock, synchronous reset SRST
// Notes:   bound to every vic_ctrl instance
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_ctrl_chk
(
    // clock and reset
    input wire logic                 CLK,
    input wire logic                 SRST,
    // bus
    input wire logic                 HSEL,
    input wire logic [1:0]           HTRANS,
    input wire logic                 HWRITE,
    input wire logic                 HREADY,
    input wire logic                 HREADYOUT,
    // core
    input wire logic                 IRQ_REQ,
    input wire logic                 IRQ_HIGH,
    input wire logic [`VIC_VECW-1:0] IRQ_VEC,
    input wire logic                 CPU_ACK,
    input wire logic                 CPU_RETURN_FROM_INTERRUPT,
    input wire logic                 CPU_RETURN_FROM_INTERRUPT_CTX,
    input wire logic                 WORKING_REGISTER_LOAD,
    input wire logic [`VIC_VECW-1:0] WORKING_REGISTER_DATA,
    input wire logic                 PC_PUSH,
    input wire logic                 PC_POP,
    input wire logic                 CTX_RESTORE,
    input wire logic [1:0]           EXEC_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    logic take;
    logic ret;
    logic acc;
    assign take = IRQ_REQ && CPU_ACK;
    assign ret  = CPU_RETURN_FROM_INTERRUPT && !take;
    assign acc  = HSEL && HTRANS[1] && HREADY;

    AST_ACK_PULSE: assert property (take |=> WORKING_REGISTER_LOAD && PC_PUSH
        && !IRQ_REQ ##1 !WORKING_REGISTER_LOAD && !PC_PUSH) else $error("bad ack pulse");
    AST_WORKING_REGISTER_VEC: assert property (take |=>
        WORKING_REGISTER_DATA == $past(IRQ_VEC)) else $error("working value wrong");
    AST_ACK_STATE: assert property (take |=> EXEC_STATE ==
        ($past(IRQ_HIGH) ? 2'b10 : 2'b01)) else $error("bad state on ack");
    AST_HIGH_QUIET: assert property (EXEC_STATE == 2'b10 |->
        !IRQ_REQ) else $error("request in high handler");
    AST_LOW_HIGHONLY: assert property (EXEC_STATE == 2'b01 &&
        IRQ_REQ |-> IRQ_HIGH) else $error("low request in low handler");
    AST_RET_POP: assert property (ret |=> PC_POP)
        else $error("no pop on return");
    AST_RET_SKIP: assert property (CPU_RETURN_FROM_INTERRUPT && !CPU_RETURN_FROM_INTERRUPT_CTX
        |=> !CTX_RESTORE) else $error("restore on plain return");
    AST_RET_RESTORE: assert property (ret && CPU_RETURN_FROM_INTERRUPT_CTX &&
        EXEC_STATE != 2'b00 |=> CTX_RESTORE) else $error("no restore");
    AST_MAIN_KEEP: assert property (ret && EXEC_STATE == 2'b00 |=>
        !CTX_RESTORE && EXEC_STATE == 2'b00) else $error("main return");
    AST_HIGH_EXIT: assert property (ret && EXEC_STATE == 2'b10 |=>
        EXEC_STATE != 2'b10) else $error("high handler not left");
    AST_RD_WAIT: assert property (acc && !HWRITE |=> !HREADYOUT
        ##1 HREADYOUT) else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (acc && HWRITE |=> HREADYOUT)
        else $error("write stalled");

    COV_NEST: cover property (EXEC_STATE == 2'b01 && take);
    COV_RESTORE: cover property (CTX_RESTORE);
    COV_READ: cover property (acc && !HWRITE ##2 HREADYOUT);
endmodule
bind vic_ctrl vic_ctrl_chk u_chk (
    .CLK, .SRST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT,
    .IRQ_REQ, .IRQ_HIGH, .IRQ_VEC, .CPU_ACK, .CPU_RETURN_FROM_INTERRUPT,
    .CPU_RETURN_FROM_INTERRUPT_CTX, .WORKING_REGISTER_LOAD, .WORKING_REGISTER_DATA, .PC_PUSH, .PC_POP,
    .CTX_RESTORE, .EXEC_STATE
);

// *** vic_core_model.sv ***
// Purpose: processor core that answers vector requests
// Assumes: same clock as the controller
// Notes:   context changes every cycle so each save differs
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_core_model
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // test control
    input  wire logic                ack_en,
    input  wire logic [3:0]          ack_dly,
    // controller side
    input  wire logic                irq_req,
    output logic                     cpu_ack,
    output logic [`VIC_CTXW-1:0]     cpu_ctx
);
    logic [3:0] wait_q;
    always_ff @(posedge clk) begin
        if (srst || !irq_req) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hf) begin
            wait_q <= wait_q + 4'h1;
        end
        // halt and take the vector after a delay
        cpu_ack <= !srst && ack_en && irq_req && !cpu_ack
            && wait_q >= ack_dly;
        cpu_ctx <= srst ? '0 : cpu_ctx + {8'h01, 64'h0, 32'h01000193};
    end
endmodule

// *** vic_ctrl_bench.sv ***
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model acks, bench drives sources and bus
// Notes:   source 1 is a summary flag
`timescale 1ns/1ns
`include "vic_consts.svh"
module vic_ctrl_bench;
    logic                 CLK, SRST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [1:0]           HTRANS, EXEC_STATE;
    logic [31:0]          HADDR, HWDATA, HRDATA, rd;
    logic [`VIC_NSRC-1:0] SRC_EVT, SRC_HWCLR;
    logic                 IRQ_REQ, IRQ_HIGH, IRQ_TABLE, CPU_ACK;
    logic [`VIC_VECW-1:0] IRQ_VEC, WORKING_REGISTER_DATA;
    logic [15:0]          IRQ_ADDR;
    logic                 CPU_RETURN_FROM_INTERRUPT, CPU_RETURN_FROM_INTERRUPT_CTX, WORKING_REGISTER_LOAD;
    logic                 PC_PUSH, PC_POP, CTX_RESTORE, ack_en;
    logic [`VIC_CTXW-1:0] CPU_CTX, CTX_DATA, ctx_main, ctx_low;
    logic [3:0]           ack_dly;
    int                   err_count = 0;
    int                   n_tests = 0;

    vic_ctrl #(.SUMMARY_MASK(144'h2)) dut (
        .CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'b010),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
        .SRC_EVT, .SRC_HWCLR, .IRQ_REQ, .IRQ_HIGH, .IRQ_VEC, .IRQ_TABLE,
        .IRQ_ADDR, .CPU_ACK, .CPU_RETURN_FROM_INTERRUPT, .CPU_RETURN_FROM_INTERRUPT_CTX, .CPU_CTX,
        .WORKING_REGISTER_LOAD, .WORKING_REGISTER_DATA, .PC_PUSH, .PC_POP, .CTX_RESTORE,
        .CTX_DATA, .EXEC_STATE);
    vic_core_model core (.clk(CLK), .srst(SRST), .ack_en, .ack_dly,
        .irq_req(IRQ_REQ), .cpu_ack(CPU_ACK), .cpu_ctx(CPU_CTX));

    always #2 CLK = ~CLK;

    task automatic chk(input string n, input logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HADDR  <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
        chk("hresp", 32'h0, {31'h0, HRESP});
    endtask
    task automatic evt(input logic [`VIC_NSRC-1:0] m);
        SRC_EVT <= m;
        @(posedge CLK);
        SRC_EVT <= '0;
    endtask
    task automatic take(input logic [7:0] v, input logic h,
                        output logic [`VIC_CTXW-1:0] c);
        int i;
        i = 0;
        while (IRQ_REQ !== 1'b1 && i < 40) begin
            @(posedge CLK);
            i++;
        end
        chk("irq_vec", {24'h0, v}, {24'h0, IRQ_VEC});
        chk("irq_high", {31'h0, h}, {31'h0, IRQ_HIGH});
        ack_en <= 1'b1;
        while (!(CPU_ACK === 1'b1 && IRQ_REQ === 1'b1) && i < 80) begin
            @(posedge CLK);
            i++;
        end
        c = CPU_CTX;
        ack_en <= 1'b0;
        @(posedge CLK);
        chk("working_register_data", {24'h0, v}, {24'h0, WORKING_REGISTER_DATA});
        chk("working_register_load", 32'h1, {31'h0, WORKING_REGISTER_LOAD});
        chk("pc_push", 32'h1, {31'h0, PC_PUSH});
        chk("exec_state", h ? 32'h2 : 32'h1, {30'h0, EXEC_STATE});
    endtask
    task automatic ret(input logic c, input logic [1:0] st);
        CPU_RETURN_FROM_INTERRUPT     <= 1'b1;
        CPU_RETURN_FROM_INTERRUPT_CTX <= c;
        @(posedge CLK);
        CPU_RETURN_FROM_INTERRUPT     <= 1'b0;
        @(posedge CLK);
        chk("pc_pop", 32'h1, {31'h0, PC_POP});
        chk("ctx_restore", {31'h0, c}, {31'h0, CTX_RESTORE});
        chk("exec_state", {30'h0, st}, {30'h0, EXEC_STATE});
    endtask

    task automatic t_reset;
        rdchk(`VIC_A_CTRL, 32'h0);
        rdchk(`VIC_A_PRIO, 32'hffffffff);
        rdchk(`VIC_A_PRIO + 8'h10, 32'h0000ffff);
        rdchk(8'h0c, 32'h0);
        chk("exec_state", 32'h0, {30'h0, EXEC_STATE});
        ret(1'b0, 2'b00);
        SRC_EVT[1] <= 1'b1;
        rdchk(`VIC_A_FLAG, 32'h2);
        wr(`VIC_A_FLAG, 32'h2);
        rdchk(`VIC_A_FLAG, 32'h2);
        SRC_EVT[1] <= 1'b0;
        rdchk(`VIC_A_FLAG, 32'h0);
    endtask
    task automatic t_natural;
        wr(`VIC_A_CTRL, 32'h3);
        wr(`VIC_A_ENAB, 32'h28);
        evt(144'h28);
        rdchk(`VIC_A_FLAG, 32'h28);
        chk("irq_addr", 32'h8, {16'h0, IRQ_ADDR});
        take(8'd3, 1'b1, ctx_main);
        rdchk(`VIC_A_CTRL, 32'h3);
        rdchk(`VIC_A_SHAD, ctx_main[31:0]);
        wr(`VIC_A_FLAG, 32'h8);
        ret(1'b0, 2'b00);
        ack_dly <= 4'd6;
        take(8'd5, 1'b1, ctx_main);
        SRC_HWCLR[5] <= 1'b1;
        @(posedge CLK);
        SRC_HWCLR[5] <= 1'b0;
        rdchk(`VIC_A_FLAG, 32'h0);
        ret(1'b1, 2'b00);
        chk("ctx_data", ctx_main[31:0], CTX_DATA[31:0]);
    endtask
    task automatic t_levels;
        wr(`VIC_A_PRIO + 8'h4, 32'hfffffeff);
        wr(`VIC_A_ENAB + 8'h4, 32'h100);
        wr(`VIC_A_ENAB + 8'h8, 32'h40);
        wr(`VIC_A_CTRL, 32'h1f);
        evt((144'h1 << 70) | (144'h1 << 40));
        take(8'd70, 1'b1, ctx_main);
        chk("irq_table", 32'h1, {31'h0, IRQ_TABLE});
        chk("irq_addr", 32'h0, {16'h0, IRQ_ADDR});
        wr(`VIC_A_FLAG + 8'h8, 32'h40);
        ret(1'b1, 2'b00);
        take(8'd40, 1'b0, ctx_main);
        evt(144'h1 << 70);
        take(8'd70, 1'b1, ctx_low);
        rdchk(`VIC_A_SHAD, ctx_low[31:0]);
        wr(`VIC_A_SHAD, 32'h5a5a1234);
        wr(`VIC_A_FLAG + 8'h8, 32'h40);
        ret(1'b1, 2'b01);
        chk("ctx_data", 32'h5a5a1234, CTX_DATA[31:0]);
        wr(`VIC_A_CTRL, 32'h0f);
        rdchk(`VIC_A_SHAD, ctx_main[31:0]);
        wr(`VIC_A_FLAG + 8'h4, 32'h100);
        ret(1'b1, 2'b00);
        chk("ctx_hi", ctx_main[103:72], CTX_DATA[103:72]);
    endtask
    task automatic t_disable;
        wr(`VIC_A_CTRL, 32'h07);
        evt(144'h1 << 40);
        take(8'd40, 1'b0, ctx_main);
        chk("irq_table", 32'h0, {31'h0, IRQ_TABLE});
        chk("irq_addr", 32'h18, {16'h0, IRQ_ADDR});
        wr(`VIC_A_CTRL, 32'h0c);
        repeat (3) @(posedge CLK);
        chk("exec_state", 32'h0, {30'h0, EXEC_STATE});
        chk("irq_req", 32'h0, {31'h0, IRQ_REQ});
        rdchk(`VIC_A_FLAG + 8'h4, 32'h100);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        CLK = 1'b0;
        SRST = 1'b1;
        HSEL = 1'b0;
        HWRITE = 1'b0;
        HTRANS = 2'b00;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        SRC_EVT = '0;
        SRC_HWCLR = '0;
        CPU_RETURN_FROM_INTERRUPT = 1'b0;
        CPU_RETURN_FROM_INTERRUPT_CTX = 1'b0;
        ack_en = 1'b0;
        ack_dly = 4'd0;
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        t_reset;
        t_natural;
        t_levels;
        t_disable;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge CLK);
        err_count++;
        stop_test;
    end
endmodule
